// ---- common/xbus_pkg.sv ----
package xbus_pkg;

   // register map, 16-bit word registers on the plain register port
   localparam logic [15:0] XBS_OFFSET = 16'h6c00; // external bus selection
   localparam logic [15:0] TOC_OFFSET = 16'h6c02; // time-out control
   localparam logic [15:0] IRQ_STAT_OFFSET = 16'h6c04; // sticky events
   localparam logic [15:0] IRQ_MASK_OFFSET = 16'h6c06; // event mask

   // field positions
   localparam int MODE_BIT = 0; // parallel/host mux mode
   localparam int RSVD_LO_BIT = 2; // reserved, read/write
   localparam int RSVD_HI_BIT = 3; // reserved, read/write
   localparam int TOC_EN_BIT = 0; // periph_timeout_enable
   localparam int EV_MEM_ERR = 0; // access to disabled memory port
   localparam int EV_HOST_ERR = 1; // access to disabled host port
   localparam int EV_MODE_WR = 2; // software changed the mode bit
   localparam int EV_W = 3;

   // reset values (mode bit resets to the strap instead)
   localparam logic [1:0] RSVD_RESET = 2'h0;
   localparam logic TOC_EN_RESET = 1'b0;
   localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

   // pin group widths
   localparam int HD_W = 8; // host data pins
   localparam int HOST_W = 10; // host data plus two control pins
   localparam int ADDR_W = 20; // parallel address pins 21..2
   localparam int DATA_W = 32; // parallel data pins
   localparam int CTL_W = 16; // parallel control pins
   localparam int PAR_W = 68; // all parallel pins
   localparam int PGP_W = 36; // parallel_gpio lines fed by parallel pins
   localparam int GPIO_W = 46; // all parallel_gpio lines

   // mux configuration
   typedef enum logic {MODE_GPIO, MODE_FULL} mux_mode_t;

endpackage

// ---- common/mux_ctl_if.sv ----
`timescale 1ns/100ps
// mode and clock enable from the register side to the pin routers
interface mux_ctl_if;
   logic mode; // 1: memory port and host port, 0: parallel_gpio
   logic ce; // freezes router state while low
   modport ctl (output mode, output ce);
   modport route (input mode, input ce);
endinterface

// ---- design/host_pin_route.sv ----
`timescale 1ns/100ps
module host_pin_route (
   input wire logic ref_clk,
   input wire logic rst,
   mux_ctl_if.route ctl,
   input wire logic [xbus_pkg::HOST_W-1:0] pin_i,
   output logic [xbus_pkg::HOST_W-1:0] pin_o,
   output logic [xbus_pkg::HOST_W-1:0] pin_oe,
   input wire logic [xbus_pkg::HD_W-1:0] port_data_o,
   input wire logic [xbus_pkg::HD_W-1:0] port_data_oe,
   output logic [xbus_pkg::HD_W-1:0] port_data_i,
   output logic port_strobe,
   output logic port_bsel,
   input wire logic [xbus_pkg::HOST_W-1:0] gpio_o,
   input wire logic [xbus_pkg::HOST_W-1:0] gpio_oe,
   output logic [xbus_pkg::HOST_W-1:0] gpio_i
);
   logic [xbus_pkg::HOST_W-1:0] pin_meta; // first stage, read by pin_sync only
   logic [xbus_pkg::HOST_W-1:0] pin_sync; // pins in the clock domain

   // two-flop synchroniser for the host pins
   always_ff @(posedge ref_clk) begin
      if (ctl.ce) begin
         pin_meta <= pin_i;
         pin_sync <= pin_meta;
      end
   end

   // routing, outputs registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_o <= '0;
         pin_oe <= '0; // pins float until mode is known
         port_data_i <= '0;
         port_strobe <= 1'b0;
         port_bsel <= 1'b0;
         gpio_i <= '0;
      end else if (ctl.ce) begin
         if (ctl.mode) begin
            // host port: data both ways, control pins are inputs
            pin_o <= {2'h0, port_data_o};
            pin_oe <= {2'h0, port_data_oe};
            port_data_i <= pin_sync[xbus_pkg::HD_W-1:0];
            port_strobe <= pin_sync[8]; // control pin 0
            port_bsel <= pin_sync[9]; // control pin 1
            gpio_i <= '0;
         end else begin
            // straight onto lines 45..36
            pin_o <= gpio_o;
            pin_oe <= gpio_oe;
            port_data_i <= '0; // host port sees an idle bus
            port_strobe <= 1'b0;
            port_bsel <= 1'b0;
            gpio_i <= pin_sync;
         end
      end
   end
endmodule // host_pin_route

// ---- design/par_pin_route.sv ----
`timescale 1ns/100ps
module par_pin_route (
   input wire logic ref_clk,
   input wire logic rst,
   mux_ctl_if.route ctl,
   input wire logic [xbus_pkg::PAR_W-1:0] pin_i,
   output logic [xbus_pkg::PAR_W-1:0] pin_o,
   output logic [xbus_pkg::PAR_W-1:0] pin_oe,
   input wire logic [xbus_pkg::PAR_W-1:0] mem_o,
   input wire logic [xbus_pkg::PAR_W-1:0] mem_oe,
   output logic [xbus_pkg::PAR_W-1:0] mem_i,
   input wire logic [xbus_pkg::PGP_W-1:0] gpio_o,
   input wire logic [xbus_pkg::PGP_W-1:0] gpio_oe,
   output logic [xbus_pkg::PGP_W-1:0] gpio_i
);
   // pin vector order: {ctl[15:0], data[31:16], data[15:0], addr[21:18], addr[17:2]}
   logic [xbus_pkg::PAR_W-1:0] pin_meta; // first stage, read by pin_sync only
   logic [xbus_pkg::PAR_W-1:0] pin_sync;

   // two-flop synchroniser for the parallel pins
   always_ff @(posedge ref_clk) begin
      if (ctl.ce) begin
         pin_meta <= pin_i;
         pin_sync <= pin_meta;
      end
   end

   // routing, outputs registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_o <= '0;
         pin_oe <= '0;
         mem_i <= '0;
         gpio_i <= '0;
      end else if (ctl.ce) begin
         if (ctl.mode) begin
            // every pin belongs to the memory port
            pin_o <= mem_o;
            pin_oe <= mem_oe;
            mem_i <= pin_sync;
            gpio_i <= '0;
         end else begin
            // reserved pins are not driven
            pin_o <= {gpio_o[35:20], gpio_o[19:4], 16'h0000, gpio_o[3:0], 16'h0000};
            pin_oe <= {gpio_oe[35:20], gpio_oe[19:4], 16'h0000, gpio_oe[3:0], 16'h0000};
            mem_i <= '0; // memory port sees an idle bus
            gpio_i <= {pin_sync[67:52], pin_sync[51:36], pin_sync[19:16]};
         end
      end
   end
endmodule // par_pin_route

// ---- design/external_bus_pin_mux.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
//
// Contract
// - host mux: ten pins, two modes
// - mode comes from strap during reset
// - strap low: all gpio, ports off
// - strap high: host port multiplexed, bit one
// - gpio mode: host pins on lines 45..36
// - mode one: memory port owns parallel pins
// - mode zero: no port may operate
// - mode bit 0, writable, resets to strap
// - memory port clock stops when unselected
// - disabled access errors when timeout enabled
// - gpio mode parallel pin mapping, reserved pins
// - memory mode: address pins always driven, data and control pins per memory port enables
//
module external_bus_pin_mux (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   // register port
   input wire logic [15:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // strap, sampled through a synchroniser
   input wire logic CONFIG_STRAP_PIN,
   // internal masters touching the ports
   input wire logic MEM_ACCESS,
   input wire logic HOST_ACCESS,
   output logic BUS_ERROR,
   output logic IRQ,
   // port enables and memory port clock gate
   output logic MEM_CLK_EN,
   output logic MEM_PORT_EN,
   output logic HOST_PORT_EN,
   // memory port side
   input wire logic [21:2] MEM_PORT_ADDR,
   input wire logic [31:0] MEM_PORT_DATA_O,
   input wire logic [31:0] MEM_PORT_DATA_OE,
   output logic [31:0] MEM_PORT_DATA_I,
   input wire logic [15:0] MEM_PORT_CTL_O,
   input wire logic [15:0] MEM_PORT_CTL_OE,
   output logic [15:0] MEM_PORT_CTL_I,
   // host port side
   input wire logic [7:0] HOST_PORT_DATA_O,
   input wire logic [7:0] HOST_PORT_DATA_OE,
   output logic [7:0] HOST_PORT_DATA_I,
   output logic HOST_ADDR_STROBE,
   output logic HOST_BYTE_SELECT,
   // parallel_gpio side
   input wire logic [45:0] PARALLEL_GPIO_O,
   input wire logic [45:0] PARALLEL_GPIO_OE,
   output logic [45:0] PARALLEL_GPIO_I,
   // parallel pins
   input wire logic [21:2] PAR_ADDR_PINS_I,
   output logic [21:2] PAR_ADDR_PINS_O,
   output logic [21:2] PAR_ADDR_PINS_OE,
   input wire logic [31:0] PAR_DATA_PINS_I,
   output logic [31:0] PAR_DATA_PINS_O,
   output logic [31:0] PAR_DATA_PINS_OE,
   input wire logic [15:0] PAR_CTL_PINS_I,
   output logic [15:0] PAR_CTL_PINS_O,
   output logic [15:0] PAR_CTL_PINS_OE,
   // host pins
   input wire logic [7:0] HOST_DATA_PINS_I,
   output logic [7:0] HOST_DATA_PINS_O,
   output logic [7:0] HOST_DATA_PINS_OE,
   input wire logic HOST_CTL_PIN0_I,
   output logic HOST_CTL_PIN0_O,
   output logic HOST_CTL_PIN0_OE,
   input wire logic HOST_CTL_PIN1_I,
   output logic HOST_CTL_PIN1_O,
   output logic HOST_CTL_PIN1_OE
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic strap_meta; // first stage, read by strap_sync only
   logic strap_sync; // strap level in the clock domain
   xbus_pkg::mux_mode_t mode; // current mux configuration
   logic [1:0] rsvd; // bits 3..2, stored but without effect
   logic toc_en; // periph_timeout_enable
   logic [xbus_pkg::EV_W-1:0] irq_stat; // sticky events
   logic [xbus_pkg::EV_W-1:0] irq_mask; // 1 lets the event through
   logic [xbus_pkg::EV_W-1:0] ev_set; // events raised this cycle
   logic [xbus_pkg::EV_W-1:0] next_irq_stat;
   logic [15:0] next_rdata;
   logic wr_xbs; // write strobe decoded per register
   logic wr_toc;
   logic wr_mask;
   logic rd_stat; // read of the status register, clears it
   logic mem_err; // disabled memory port touched, errors enabled
   logic host_err; // same for the host port
   logic mode_flip; // write would change the mode bit
   logic [xbus_pkg::PAR_W-1:0] par_mem_o; // memory port, pin vector order
   logic [xbus_pkg::PAR_W-1:0] par_mem_oe;
   logic [xbus_pkg::PAR_W-1:0] par_mem_i;
   logic [xbus_pkg::PAR_W-1:0] par_pin_o;
   logic [xbus_pkg::PAR_W-1:0] par_pin_oe;
   logic [xbus_pkg::HOST_W-1:0] host_pin_o;
   logic [xbus_pkg::HOST_W-1:0] host_pin_oe;

   mux_ctl_if mctl (); // mode and enable for both routers

   ////////////////////////////////////////////////////////////////////////////
   // strap sampling and mode bit

   // strap synchroniser runs through reset so the level is ready at release
   always_ff @(posedge REF_CLK) begin
      if (CE) begin
         strap_meta <= CONFIG_STRAP_PIN;
         strap_sync <= strap_meta;
      end
   end

   // mode follows the strap while reset is high; the last reset edge wins,
   // so the value held is the one present at release
   always_ff @(posedge REF_CLK) begin
      if (CE) begin
         if (RST) begin
            mode <= strap_sync ? xbus_pkg::MODE_FULL : xbus_pkg::MODE_GPIO;
         end else if (wr_xbs) begin
            // honoured, although software is expected not to do it
            mode <= WDATA[xbus_pkg::MODE_BIT] ? xbus_pkg::MODE_FULL : xbus_pkg::MODE_GPIO;
         end
      end
   end

   // reserved bits 3..2 are plain storage
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rsvd <= xbus_pkg::RSVD_RESET;
      end else if (CE && wr_xbs) begin
         rsvd <= WDATA[xbus_pkg::RSVD_HI_BIT:xbus_pkg::RSVD_LO_BIT];
      end
   end

   // time-out control
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         toc_en <= xbus_pkg::TOC_EN_RESET;
      end else if (CE && wr_toc) begin
         toc_en <= WDATA[xbus_pkg::TOC_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port decode

   // strobes are ignored while CE is low; the master must not issue then
   always_comb begin
      wr_xbs = WR && (ADDR == xbus_pkg::XBS_OFFSET);
      wr_toc = WR && (ADDR == xbus_pkg::TOC_OFFSET);
      wr_mask = WR && (ADDR == xbus_pkg::IRQ_MASK_OFFSET);
      rd_stat = RD && (ADDR == xbus_pkg::IRQ_STAT_OFFSET);
   end

   // read mux; unmapped addresses and idle cycles read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (RD) begin
         case (ADDR)
            xbus_pkg::XBS_OFFSET: begin
               // bits 15..4 and 1 read zero
               next_rdata[xbus_pkg::RSVD_HI_BIT:xbus_pkg::RSVD_LO_BIT] = rsvd;
               next_rdata[xbus_pkg::MODE_BIT] = (mode == xbus_pkg::MODE_FULL);
            end
            xbus_pkg::TOC_OFFSET: begin
               next_rdata[xbus_pkg::TOC_EN_BIT] = toc_en;
            end
            xbus_pkg::IRQ_STAT_OFFSET: begin
               next_rdata[xbus_pkg::EV_W-1:0] = irq_stat;
            end
            xbus_pkg::IRQ_MASK_OFFSET: begin
               next_rdata[xbus_pkg::EV_W-1:0] = irq_mask;
            end
            default: begin
               next_rdata = 16'h0000;
            end
         endcase
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RDATA <= 16'h0000;
      end else if (CE) begin
         RDATA <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // disabled-module accesses

   // only the gpio mode disables the ports; both go together
   always_comb begin
      mem_err = MEM_ACCESS && (mode == xbus_pkg::MODE_GPIO) && toc_en;
      host_err = HOST_ACCESS && (mode == xbus_pkg::MODE_GPIO) && toc_en;
      mode_flip = wr_xbs && (WDATA[xbus_pkg::MODE_BIT] != (mode == xbus_pkg::MODE_FULL));
   end

   // one-cycle error answer, one cycle after the access
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         BUS_ERROR <= 1'b0;
      end else if (CE) begin
         BUS_ERROR <= mem_err || host_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask

   // set wins over the clearing read so no event is lost
   always_comb begin
      ev_set = '0;
      ev_set[xbus_pkg::EV_MEM_ERR] = mem_err;
      ev_set[xbus_pkg::EV_HOST_ERR] = host_err;
      ev_set[xbus_pkg::EV_MODE_WR] = mode_flip;
      next_irq_stat = (rd_stat ? '0 : irq_stat) | ev_set;
   end

   // sticky status
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_stat <= '0;
      end else if (CE) begin
         irq_stat <= next_irq_stat;
      end
   end

   // mask register
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_mask <= xbus_pkg::IRQ_MASK_RESET;
      end else if (CE && wr_mask) begin
         irq_mask <= WDATA[xbus_pkg::EV_W-1:0];
      end
   end

   // level interrupt, gated from registers only
   assign IRQ = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // port enables and memory port clock gate

   // registered so the gate changes only on a clean edge; the clock cell
   // outside latches this enable again before it gates the clock
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         MEM_CLK_EN <= 1'b0;
         MEM_PORT_EN <= 1'b0;
         HOST_PORT_EN <= 1'b0;
      end else if (CE) begin
         MEM_CLK_EN <= (mode == xbus_pkg::MODE_FULL);
         MEM_PORT_EN <= (mode == xbus_pkg::MODE_FULL);
         HOST_PORT_EN <= (mode == xbus_pkg::MODE_FULL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin routers

   assign mctl.mode = (mode == xbus_pkg::MODE_FULL);
   assign mctl.ce = CE;

   // memory port in pin vector order; address lines are always driven
   assign par_mem_o = {MEM_PORT_CTL_O, MEM_PORT_DATA_O, MEM_PORT_ADDR};
   assign par_mem_oe = {MEM_PORT_CTL_OE, MEM_PORT_DATA_OE, {xbus_pkg::ADDR_W{1'b1}}};
   assign MEM_PORT_CTL_I = par_mem_i[67:52];
   assign MEM_PORT_DATA_I = par_mem_i[51:20];

   // parallel pins: 20 address, 32 data, 16 control
   par_pin_route u_par (
      .ref_clk(REF_CLK),
      .rst(RST),
      .ctl(mctl.route),
      .pin_i({PAR_CTL_PINS_I, PAR_DATA_PINS_I, PAR_ADDR_PINS_I}),
      .pin_o(par_pin_o),
      .pin_oe(par_pin_oe),
      .mem_o(par_mem_o),
      .mem_oe(par_mem_oe),
      .mem_i(par_mem_i),
      .gpio_o(PARALLEL_GPIO_O[35:0]),
      .gpio_oe(PARALLEL_GPIO_OE[35:0]),
      .gpio_i(PARALLEL_GPIO_I[35:0])
   );

   assign PAR_CTL_PINS_O = par_pin_o[67:52];
   assign PAR_CTL_PINS_OE = par_pin_oe[67:52];
   assign PAR_DATA_PINS_O = par_pin_o[51:20];
   assign PAR_DATA_PINS_OE = par_pin_oe[51:20];
   assign PAR_ADDR_PINS_O = par_pin_o[19:0];
   assign PAR_ADDR_PINS_OE = par_pin_oe[19:0];

   // host pins: eight data, two control, two modes
   host_pin_route u_host (
      .ref_clk(REF_CLK),
      .rst(RST),
      .ctl(mctl.route),
      .pin_i({HOST_CTL_PIN1_I, HOST_CTL_PIN0_I, HOST_DATA_PINS_I}),
      .pin_o(host_pin_o),
      .pin_oe(host_pin_oe),
      .port_data_o(HOST_PORT_DATA_O),
      .port_data_oe(HOST_PORT_DATA_OE),
      .port_data_i(HOST_PORT_DATA_I),
      .port_strobe(HOST_ADDR_STROBE),
      .port_bsel(HOST_BYTE_SELECT),
      .gpio_o(PARALLEL_GPIO_O[45:36]),
      .gpio_oe(PARALLEL_GPIO_OE[45:36]),
      .gpio_i(PARALLEL_GPIO_I[45:36])
   );

   assign HOST_DATA_PINS_O = host_pin_o[7:0];
   assign HOST_DATA_PINS_OE = host_pin_oe[7:0];
   assign HOST_CTL_PIN0_O = host_pin_o[8];
   assign HOST_CTL_PIN0_OE = host_pin_oe[8];
   assign HOST_CTL_PIN1_O = host_pin_o[9];
   assign HOST_CTL_PIN1_OE = host_pin_oe[9];

endmodule // external_bus_pin_mux

// ---- test/xbus_mux_chk.sv ----
`timescale 1ns/100ps
// watches the top ports only; the time-out enable lives inside, so errors are checked one way
module xbus_mux_chk (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic MEM_ACCESS,
   input wire logic HOST_ACCESS,
   input wire logic WR,
   input wire logic BUS_ERROR,
   input wire logic MEM_CLK_EN,
   input wire logic MEM_PORT_EN,
   input wire logic HOST_PORT_EN,
   input wire logic [21:2] MEM_PORT_ADDR,
   input wire logic [31:0] MEM_PORT_DATA_O,
   input wire logic [31:0] MEM_PORT_DATA_OE,
   input wire logic [31:0] MEM_PORT_DATA_I,
   input wire logic [7:0] HOST_PORT_DATA_O,
   input wire logic [7:0] HOST_PORT_DATA_I,
   input wire logic HOST_ADDR_STROBE,
   input wire logic [45:0] PARALLEL_GPIO_O,
   input wire logic [21:2] PAR_ADDR_PINS_O,
   input wire logic [21:2] PAR_ADDR_PINS_OE,
   input wire logic [31:0] PAR_DATA_PINS_O,
   input wire logic [31:0] PAR_DATA_PINS_OE,
   input wire logic [15:0] PAR_CTL_PINS_O,
   input wire logic [7:0] HOST_DATA_PINS_O,
   input wire logic HOST_CTL_PIN0_I,
   input wire logic HOST_CTL_PIN0_O,
   input wire logic HOST_CTL_PIN0_OE,
   input wire logic HOST_CTL_PIN1_O
);
   // one clock domain, so clocking and reset are declared once
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   en_match_a: assert property (MEM_CLK_EN == MEM_PORT_EN
      && HOST_PORT_EN == MEM_PORT_EN)
      else $error("port enables or clock gate disagree");
   en_stable_a: assert property (!$past(RST, 2) && !$past(WR, 2)
      |-> $stable(MEM_PORT_EN))
      else $error("mode moved without a register write");
   err_cause_a: assert property (BUS_ERROR |->
      $past(MEM_ACCESS || HOST_ACCESS) && !$past(MEM_PORT_EN))
      else $error("bus error without an access to a disabled port");
   gpio_par_a: assert property (!MEM_PORT_EN && !$past(RST) |-> {PAR_CTL_PINS_O,
      PAR_DATA_PINS_O[31:16], PAR_ADDR_PINS_O[21:18]} == $past(PARALLEL_GPIO_O[35:0]))
      else $error("parallel pins not routed to gpio lines");
   gpio_rsvd_a: assert property (!MEM_PORT_EN |-> PAR_ADDR_PINS_OE[17:2] == 16'h0
      && PAR_DATA_PINS_OE[15:0] == 16'h0)
      else $error("reserved parallel pin driven");
   gpio_host_a: assert property (!HOST_PORT_EN && !$past(RST) |-> {HOST_CTL_PIN1_O,
      HOST_CTL_PIN0_O, HOST_DATA_PINS_O} == $past(PARALLEL_GPIO_O[45:36]))
      else $error("host pins not routed to gpio lines");
   mem_map_a: assert property (MEM_PORT_EN && !$past(RST) |->
      PAR_DATA_PINS_O == $past(MEM_PORT_DATA_O) && PAR_DATA_PINS_OE == $past(MEM_PORT_DATA_OE)
      && PAR_ADDR_PINS_O == $past(MEM_PORT_ADDR))
      else $error("memory port not routed to parallel pins");
   host_out_a: assert property (HOST_PORT_EN && !$past(RST) |->
      HOST_DATA_PINS_O == $past(HOST_PORT_DATA_O) && !HOST_CTL_PIN0_OE)
      else $error("host port not routed to host pins");
   host_strobe_a: assert property (HOST_PORT_EN && $past(HOST_PORT_EN, 3)
      && !$past(RST) && !$past(RST, 3) |-> HOST_ADDR_STROBE == $past(HOST_CTL_PIN0_I, 3))
      else $error("address strobe does not follow control pin 0");
   port_off_a: assert property (!MEM_PORT_EN && !$past(RST) |->
      MEM_PORT_DATA_I == 32'h0 && HOST_PORT_DATA_I == 8'h0)
      else $error("disabled port sees pin data");
endmodule // xbus_mux_chk

bind external_bus_pin_mux xbus_mux_chk i_chk (.*);

// ---- test/xbus_far_end.sv ----
`timescale 1ns/100ps
// far side of the pins: memory or host, driving every line the chip releases
module xbus_far_end (
   input wire logic [67:0] par_o,
   input wire logic [67:0] par_oe,
   input wire logic [9:0] host_o,
   input wire logic [9:0] host_oe,
   input wire logic [67:0] par_drv,
   input wire logic [9:0] host_drv,
   output logic [67:0] par_i,
   output logic [9:0] host_i
);
   ////////////////////////////////////////
   // wire level: the chip wins where it drives, the far side elsewhere
   assign par_i = (par_o & par_oe) | (par_drv & ~par_oe);
   assign host_i = (host_o & host_oe) | (host_drv & ~host_oe);
endmodule // xbus_far_end

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
   logic REF_CLK = 1'b0, RST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
   logic CONFIG_STRAP_PIN = 1'b0, MEM_ACCESS = 1'b0, HOST_ACCESS = 1'b0;
   logic [15:0] ADDR = 16'h0, WDATA = 16'h0, RDATA;
   logic [21:2] MEM_PORT_ADDR = 20'h0, PAR_ADDR_PINS_O, PAR_ADDR_PINS_OE;
   logic [31:0] MEM_PORT_DATA_O = 32'h0, MEM_PORT_DATA_OE = 32'h0, MEM_PORT_DATA_I;
   logic [15:0] MEM_PORT_CTL_O = 16'h0, MEM_PORT_CTL_OE = 16'h0, MEM_PORT_CTL_I;
   logic [7:0] HOST_PORT_DATA_O = 8'h0, HOST_PORT_DATA_OE = 8'h0, HOST_PORT_DATA_I;
   logic [45:0] PARALLEL_GPIO_O = 46'h0, PARALLEL_GPIO_OE = 46'h0, PARALLEL_GPIO_I;
   logic [67:0] par_drv = 68'h9c3a55e17b2d46f08; // far side pattern on released lines
   logic [9:0] host_drv = 10'h2b5;
   logic BUS_ERROR, IRQ, MEM_CLK_EN, MEM_PORT_EN, HOST_PORT_EN, HOST_ADDR_STROBE, HOST_BYTE_SELECT;
   logic [31:0] PAR_DATA_PINS_O, PAR_DATA_PINS_OE;
   logic [15:0] PAR_CTL_PINS_O, PAR_CTL_PINS_OE;
   logic [7:0] HOST_DATA_PINS_O, HOST_DATA_PINS_OE;
   logic HOST_CTL_PIN0_O, HOST_CTL_PIN0_OE, HOST_CTL_PIN1_O, HOST_CTL_PIN1_OE;
   wire [21:2] PAR_ADDR_PINS_I;
   wire [31:0] PAR_DATA_PINS_I;
   wire [15:0] PAR_CTL_PINS_I;
   wire [7:0] HOST_DATA_PINS_I;
   wire HOST_CTL_PIN0_I, HOST_CTL_PIN1_I;
   // whole pin groups, address on top, control pins at the bottom
   wire [67:0] par_o = {PAR_ADDR_PINS_O, PAR_DATA_PINS_O, PAR_CTL_PINS_O};
   wire [67:0] par_oe = {PAR_ADDR_PINS_OE, PAR_DATA_PINS_OE, PAR_CTL_PINS_OE};
   wire [9:0] host_o = {HOST_DATA_PINS_O, HOST_CTL_PIN1_O, HOST_CTL_PIN0_O};
   wire [9:0] host_oe = {HOST_DATA_PINS_OE, HOST_CTL_PIN1_OE, HOST_CTL_PIN0_OE};
   int fails = 0, checks = 0;
   localparam logic [45:0] GP = 46'h2a5c3b1d9e47; // gpio output pattern

   always #5 REF_CLK = ~REF_CLK;

   external_bus_pin_mux i_dut (.*);
   xbus_far_end i_far (.par_o(par_o), .par_oe(par_oe), .host_o(host_o), .host_oe(host_oe),
      .par_drv(par_drv), .host_drv(host_drv),
      .par_i({PAR_ADDR_PINS_I, PAR_DATA_PINS_I, PAR_CTL_PINS_I}),
      .host_i({HOST_DATA_PINS_I, HOST_CTL_PIN1_I, HOST_CTL_PIN0_I}));
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [67:0] e, input logic [67:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 chk(n, {52'h0, e}, {52'h0, RDATA});
   endtask

   // strap held through the whole reset so it crosses the synchroniser
   task automatic do_reset(input logic s);
      @(posedge REF_CLK);
      RST <= 1'b1;
      CONFIG_STRAP_PIN <= s;
      repeat (16) @(posedge REF_CLK);
      RST <= 1'b0;
   endtask

   task automatic hit(input logic host, input logic e);
      @(posedge REF_CLK);
      MEM_ACCESS <= !host;
      HOST_ACCESS <= host;
      @(posedge REF_CLK);
      MEM_ACCESS <= 1'b0;
      HOST_ACCESS <= 1'b0;
      #1 chk("bus error", {67'h0, e}, {67'h0, BUS_ERROR});
   endtask
   ////////////////////////////////////////
   task automatic t_gpio();
      CONFIG_STRAP_PIN <= 1'b1; // later strap activity must not matter
      rd(xbus_pkg::XBS_OFFSET, 16'h0, "mode bit");
      chk("enables", 68'h0, {MEM_CLK_EN, MEM_PORT_EN, HOST_PORT_EN});
      wr(xbus_pkg::XBS_OFFSET, 16'hfff2);
      rd(xbus_pkg::XBS_OFFSET, 16'h0, "read-only bits");
      rd(16'h6c08, 16'h0, "unmapped");
      rd(xbus_pkg::IRQ_MASK_OFFSET, 16'h0, "mask reset");
      PARALLEL_GPIO_O <= GP;
      PARALLEL_GPIO_OE <= '1;
      repeat (2) @(posedge REF_CLK);
      #1 chk("par out", {GP[3:0], 16'h0, GP[19:4], 16'h0, GP[35:20]}, par_o);
      chk("par oe", {4'hf, 16'h0, 16'hffff, 16'h0, 16'hffff}, par_oe);
      chk("host out", {GP[43:36], GP[45], GP[44]}, host_o);
      PARALLEL_GPIO_OE <= '0;
      repeat (4) @(posedge REF_CLK);
      #1 chk("gpio in", {host_drv[1:0], host_drv[9:2], par_drv[15:0], par_drv[47:32],
         par_drv[67:64]}, PARALLEL_GPIO_I);
      chk("ports off", 68'h0, {MEM_PORT_DATA_I, HOST_PORT_DATA_I, HOST_ADDR_STROBE});
      rd(xbus_pkg::XBS_OFFSET, 16'h0, "strap ignored");
      $display("test gpio mode done");
   endtask

   task automatic t_err();
      hit(1'b0, 1'b0);
      wr(xbus_pkg::TOC_OFFSET, 16'h1);
      wr(xbus_pkg::IRQ_MASK_OFFSET, 16'h1);
      hit(1'b0, 1'b1);
      hit(1'b1, 1'b1);
      chk("irq", 68'h1, {67'h0, IRQ});
      rd(xbus_pkg::IRQ_STAT_OFFSET, 16'h3, "status");
      chk("irq cleared", 68'h0, {67'h0, IRQ});
      hit(1'b1, 1'b1);
      chk("irq masked", 68'h0, {67'h0, IRQ});
      rd(xbus_pkg::IRQ_STAT_OFFSET, 16'h2, "status masked");
      $display("test disabled access done");
   endtask

   task automatic t_full();
      do_reset(1'b1);
      rd(xbus_pkg::XBS_OFFSET, 16'h1, "mode bit");
      chk("enables", 68'h7, {MEM_CLK_EN, MEM_PORT_EN, HOST_PORT_EN});
      wr(xbus_pkg::TOC_OFFSET, 16'h1);
      hit(1'b0, 1'b0);
      hit(1'b1, 1'b0);
      MEM_PORT_ADDR <= 20'hb3c5a;
      MEM_PORT_DATA_O <= 32'h5a0fc3e1;
      MEM_PORT_DATA_OE <= '1;
      MEM_PORT_CTL_O <= 16'h9d27;
      MEM_PORT_CTL_OE <= '1;
      HOST_PORT_DATA_O <= 8'h6e;
      HOST_PORT_DATA_OE <= '1;
      repeat (2) @(posedge REF_CLK);
      #1 chk("par out", {20'hb3c5a, 32'h5a0fc3e1, 16'h9d27}, par_o);
      chk("par oe", '1, par_oe);
      chk("host out", {8'h6e, 2'h0}, host_o & 10'h3fc);
      chk("host oe", 10'h3fc, host_oe);
      MEM_PORT_DATA_OE <= '0;
      MEM_PORT_CTL_OE <= '0;
      HOST_PORT_DATA_OE <= '0;
      par_drv <= ~par_drv; // far side changes its pattern
      host_drv <= 10'h14a;
      repeat (4) @(posedge REF_CLK);
      #1 chk("mem in", par_drv[47:0], {MEM_PORT_DATA_I, MEM_PORT_CTL_I});
      chk("host in", host_drv,
         {HOST_PORT_DATA_I, HOST_BYTE_SELECT, HOST_ADDR_STROBE});
      chk("gpio off", 68'h0, PARALLEL_GPIO_I);
      $display("test full mode done");
   endtask
   ////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      do_reset(1'b0);
      t_gpio();
      t_err();
      t_full();
      summarize();
   end
endmodule // tb
